// File: design/lus_readout.sv
// Operation
// - Write opens with start, address, direction
// - Second write byte loads register pointer
// - Further bytes stored sequentially until stop
// - Read transfer shifts out pointed register
// - Pointer bits 5:0 location, bit 6 inhibit
// - Inhibit clear by default, pointer advances
// - Inhibit set keeps pointer fixed
// - Burst reads and writes over contiguous registers
// - Open-drain interrupt, drives low only
// - Interrupt held until host clears it
// - Overflow saturates result, 24 or 16 bit
// - Results recover automatically within range
// - Integration default 24.4 us, gain lengthens
// - Visible and infrared gains independent
// - Infrared result on its own registers
// - Infrared skipped when channel list disables
// - Signal minus dark from paired converters
// - Phases 155 us, 48.8 us, 48.8us times 2^gain
// - Forced or autonomous start, interrupt on events
// - Power states active, suspend, sleep
// - Answers slave address 0x55 or 0x52
// - Pointer bit 7 zero, locations 0x00-0x3F
`default_nettype none
module lus_readout #(
    parameter int CTRL_SETUP_CYCLES = lus_pkg::CTRL_SETUP_CYC,
    parameter int RATE_TICK_CYCLES = lus_pkg::RATE_TICK_CYC,
    // Arbitrary identification value
    parameter logic [7:0] PART_ID = 8'h5A
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    output logic int_out,
    output logic int_oe_n_out,
    input wire logic [23:0] vis_sig_in,
    input wire logic [23:0] vis_dark_in,
    input wire logic vis_ovf_in,
    input wire logic [23:0] ir_sig_in,
    input wire logic [23:0] ir_dark_in,
    input wire logic ir_ovf_in,
    output logic adc_sel_ir_out,
    output logic adc_integrate_out,
    output lus_pkg::lus_pwr_t power_state_out,
    output logic meas_busy_out
);
    import lus_pkg::*;

    if (CTRL_SETUP_CYCLES < 1 || CTRL_SETUP_CYCLES >= 2 ** TMR_W) begin : g_c
        $error("CTRL_SETUP_CYCLES out of range");
    end
    if (RATE_TICK_CYCLES < 1 || RATE_TICK_CYCLES >= 2 ** TMR_W) begin : g_r
        $error("RATE_TICK_CYCLES out of range");
    end

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        lus_i2c_st_t i2c_st;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic rw;
        logic acked;
        logic [5:0] ptr;
        logic inhibit;
        logic sda_oe_n;
        logic pin_low;
        logic int_oe_n;
        logic [63:0][7:0] mem;
        lus_seq_st_t seq_st;
        lus_pwr_t pwr;
        logic ch_ir;
        logic auto_on;
        logic pend;
        logic vis_above;
        logic integ;
        logic busy;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] tick;
        logic [7:0] rate_cnt;
    } lus_state_t;

    function automatic lus_state_t rst_val();
        lus_state_t r;
        r = '0;
        r.scl_s1 = 1'b1;
        r.scl_s2 = 1'b1;
        r.scl_s3 = 1'b1;
        r.sda_s1 = 1'b1;
        r.sda_s2 = 1'b1;
        r.sda_s3 = 1'b1;
        r.i2c_st = I2C_IDLE;
        r.sda_oe_n = 1'b1;
        r.int_oe_n = 1'b1;
        r.mem[REG_PART_ID] = PART_ID;
        // Both channels enabled after reset
        r.mem[REG_CHAN_SEL] = CHAN_SEL_RST;
        r.seq_st = SEQ_SLEEP;
        r.pwr = PWR_SLEEP;
        return r;
    endfunction

    localparam lus_state_t RST_STATE = rst_val();

    lus_state_t st_ff;
    lus_state_t nxt_st;

    logic scl_rise, scl_fall, start_c, stop_c;
    logic [5:0] nptr;
    logic [7:0] irq_set;
    logic vis_en, ir_en, res24, sat24, sat16, above, ovf;
    logic [3:0] gain;
    logic [TMR_W-1:0] conv_len, integ_len;
    logic [23:0] sig, dark, r24;
    logic [24:0] diff;
    logic [15:0] r16, val16;
    logic [5:0] base;

    always_comb begin
        nxt_st = st_ff;
        irq_set = '0;
        nxt_st.scl_s1 = scl_in;
        nxt_st.scl_s2 = st_ff.scl_s1;
        nxt_st.scl_s3 = st_ff.scl_s2;
        nxt_st.sda_s1 = sda_in;
        nxt_st.sda_s2 = st_ff.sda_s1;
        nxt_st.sda_s3 = st_ff.sda_s2;
        scl_rise = st_ff.scl_s2 & ~st_ff.scl_s3;
        scl_fall = ~st_ff.scl_s2 & st_ff.scl_s3;
        start_c = st_ff.scl_s2 & st_ff.scl_s3 & st_ff.sda_s3 & ~st_ff.sda_s2;
        stop_c = st_ff.scl_s2 & st_ff.scl_s3 & ~st_ff.sda_s3 & st_ff.sda_s2;
        nptr = st_ff.inhibit ? st_ff.ptr : st_ff.ptr + 6'h01;
        vis_en = st_ff.mem[REG_CHAN_SEL][CHAN_VIS_BIT];
        ir_en = st_ff.mem[REG_CHAN_SEL][CHAN_IR_BIT];
        res24 = st_ff.mem[REG_RES_MODE][RES24_BIT];
        gain = st_ff.ch_ir ? st_ff.mem[REG_IR_GAIN][3:0]
                           : st_ff.mem[REG_VIS_GAIN][3:0];
        conv_len = TMR_W'(CONV_UNIT_CYC) << gain;
        integ_len = TMR_W'(INTEG_CYC) << gain;
        sig = st_ff.ch_ir ? ir_sig_in : vis_sig_in;
        dark = st_ff.ch_ir ? ir_dark_in : vis_dark_in;
        ovf = st_ff.ch_ir ? ir_ovf_in : vis_ovf_in;
        diff = {1'b0, sig} - {1'b0, dark};
        sat24 = ovf | (~diff[24] & diff[23]);
        sat16 = ovf | (~diff[24] & (|diff[23:16]));
        r24 = sat24 ? SAT24 : (diff[24] ? 24'h000000 : diff[23:0]);
        r16 = sat16 ? SAT16 : (diff[24] ? 16'h0000 : diff[15:0]);
        val16 = res24 ? r24[23:8] : r16;
        above = val16 > {st_ff.mem[REG_THRESH_H], st_ff.mem[REG_THRESH_L]};
        base = st_ff.ch_ir ? REG_IR_RES0 : REG_VIS_RES0;

        if (st_ff.auto_on && st_ff.mem[REG_MEAS_RATE] != 8'h00) begin
            if (st_ff.tick == TMR_W'(RATE_TICK_CYCLES - 1)) begin
                nxt_st.tick = '0;
                if (st_ff.rate_cnt + 8'h01 >= st_ff.mem[REG_MEAS_RATE]) begin
                    nxt_st.rate_cnt = 8'h00;
                    nxt_st.pend = 1'b1;
                end else begin
                    nxt_st.rate_cnt = st_ff.rate_cnt + 8'h01;
                end
            end else begin
                nxt_st.tick = st_ff.tick + TMR_W'(1);
            end
        end else begin
            nxt_st.tick = '0;
            nxt_st.rate_cnt = 8'h00;
        end

        case (st_ff.seq_st)
            SEQ_SLEEP: begin
                nxt_st.pwr = PWR_SLEEP;
                nxt_st.busy = 1'b0;
                if (st_ff.pend) begin
                    nxt_st.pend = 1'b0;
                    if (vis_en | ir_en) begin
                        nxt_st.ch_ir = ~vis_en;
                        nxt_st.seq_st = SEQ_CTRL;
                        nxt_st.tmr = '0;
                        nxt_st.pwr = PWR_ACTIVE;
                        nxt_st.busy = 1'b1;
                    end
                end
            end
            SEQ_CTRL: begin
                if (st_ff.tmr == TMR_W'(CTRL_SETUP_CYCLES - 1)) begin
                    nxt_st.seq_st = SEQ_ADCSET;
                    nxt_st.tmr = '0;
                    nxt_st.pwr = PWR_SUSPEND;
                end else begin
                    nxt_st.tmr = st_ff.tmr + TMR_W'(1);
                end
            end
            SEQ_ADCSET: begin
                if (st_ff.tmr == TMR_W'(ADC_SETUP_CYC - 1)) begin
                    nxt_st.seq_st = SEQ_CONV;
                    nxt_st.tmr = '0;
                    nxt_st.integ = 1'b1;
                end else begin
                    nxt_st.tmr = st_ff.tmr + TMR_W'(1);
                end
            end
            SEQ_CONV: begin
                nxt_st.integ = (st_ff.tmr + TMR_W'(1)) < integ_len;
                if (st_ff.tmr == conv_len - TMR_W'(1)) begin
                    nxt_st.seq_st = SEQ_STORE;
                    nxt_st.tmr = '0;
                    nxt_st.integ = 1'b0;
                    nxt_st.pwr = PWR_ACTIVE;
                end else begin
                    nxt_st.tmr = st_ff.tmr + TMR_W'(1);
                end
            end
            SEQ_STORE: begin
                if (res24) begin
                    nxt_st.mem[base] = r24[23:16];
                    nxt_st.mem[base + 6'h01] = r24[15:8];
                    nxt_st.mem[base + 6'h02] = r24[7:0];
                end else begin
                    nxt_st.mem[base] = r16[15:8];
                    nxt_st.mem[base + 6'h01] = r16[7:0];
                    nxt_st.mem[base + 6'h02] = 8'h00;
                end
                if (st_ff.ch_ir) begin
                    irq_set[IRQ_IR_BIT] = 1'b1;
                end else begin
                    irq_set[IRQ_VIS_BIT] = 1'b1;
                    irq_set[IRQ_THR_BIT] = above & ~st_ff.vis_above;
                    nxt_st.vis_above = above;
                end
                if (!st_ff.ch_ir && ir_en) begin
                    nxt_st.ch_ir = 1'b1;
                    nxt_st.seq_st = SEQ_CTRL;
                end else begin
                    nxt_st.seq_st = SEQ_SLEEP;
                    nxt_st.pwr = PWR_SLEEP;
                    nxt_st.busy = 1'b0;
                end
            end
            default: begin
                nxt_st.seq_st = SEQ_SLEEP;
                nxt_st.pwr = PWR_SLEEP;
            end
        endcase

        if (start_c) begin
            nxt_st.i2c_st = I2C_ADDR;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            nxt_st.i2c_st = I2C_IDLE;
            nxt_st.sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            case (st_ff.i2c_st)
                I2C_ADDR, I2C_PTR, I2C_WDATA: begin
                    nxt_st.shift = {st_ff.shift[6:0], st_ff.sda_s2};
                    nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                end
                I2C_RDATA: nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                I2C_RACK: nxt_st.acked = ~st_ff.sda_s2;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (st_ff.i2c_st)
                I2C_ADDR: begin
                    if (st_ff.bit_cnt == 4'h8) begin
                        if (st_ff.shift[7:1] == SLV_ADDR_MAIN ||
                            st_ff.shift[7:1] == SLV_ADDR_ALT) begin
                            nxt_st.sda_oe_n = 1'b0;
                            nxt_st.rw = st_ff.shift[0];
                            nxt_st.i2c_st = I2C_ADDR_ACK;
                        end else begin
                            nxt_st.i2c_st = I2C_IDLE;
                        end
                    end
                end
                I2C_ADDR_ACK: begin
                    nxt_st.bit_cnt = 4'h0;
                    if (st_ff.rw) begin
                        nxt_st.shift = st_ff.mem[st_ff.ptr];
                        nxt_st.sda_oe_n = st_ff.mem[st_ff.ptr][7];
                        nxt_st.i2c_st = I2C_RDATA;
                    end else begin
                        nxt_st.sda_oe_n = 1'b1;
                        nxt_st.i2c_st = I2C_PTR;
                    end
                end
                I2C_PTR: begin
                    if (st_ff.bit_cnt == 4'h8) begin
                        nxt_st.ptr = st_ff.shift[5:0];
                        nxt_st.inhibit = st_ff.shift[PTR_INHIBIT_BIT];
                        nxt_st.sda_oe_n = 1'b0;
                        nxt_st.i2c_st = I2C_PTR_ACK;
                    end
                end
                I2C_PTR_ACK, I2C_WDATA_ACK: begin
                    nxt_st.sda_oe_n = 1'b1;
                    nxt_st.bit_cnt = 4'h0;
                    nxt_st.i2c_st = I2C_WDATA;
                end
                I2C_WDATA: begin
                    if (st_ff.bit_cnt == 4'h8) begin
                        case (st_ff.ptr)
                            REG_COMMAND: begin
                                nxt_st.mem[REG_COMMAND] = st_ff.shift;
                                if (st_ff.shift == CMD_FORCE) begin
                                    nxt_st.pend = 1'b1;
                                end else if (st_ff.shift == CMD_START) begin
                                    nxt_st.auto_on = 1'b1;
                                end else if (st_ff.shift == CMD_PAUSE) begin
                                    nxt_st.auto_on = 1'b0;
                                end
                            end
                            REG_CHAN_SEL, REG_VIS_GAIN, REG_IR_GAIN,
                            REG_MEAS_RATE, REG_RES_MODE, REG_IRQ_ENABLE,
                            REG_THRESH_H, REG_THRESH_L:
                                nxt_st.mem[st_ff.ptr] = st_ff.shift;
                            REG_IRQ_STATUS:
                                nxt_st.mem[REG_IRQ_STATUS] =
                                    st_ff.mem[REG_IRQ_STATUS] & ~st_ff.shift;
                            default: ;
                        endcase
                        nxt_st.ptr = nptr;
                        nxt_st.sda_oe_n = 1'b0;
                        nxt_st.i2c_st = I2C_WDATA_ACK;
                    end
                end
                I2C_RDATA: begin
                    if (st_ff.bit_cnt == 4'h8) begin
                        nxt_st.sda_oe_n = 1'b1;
                        nxt_st.ptr = nptr;
                        nxt_st.i2c_st = I2C_RACK;
                    end else begin
                        nxt_st.shift = {st_ff.shift[6:0], 1'b0};
                        nxt_st.sda_oe_n = st_ff.shift[6];
                    end
                end
                I2C_RACK: begin
                    if (st_ff.acked) begin
                        nxt_st.shift = st_ff.mem[st_ff.ptr];
                        nxt_st.sda_oe_n = st_ff.mem[st_ff.ptr][7];
                        nxt_st.bit_cnt = 4'h0;
                        nxt_st.i2c_st = I2C_RDATA;
                    end else begin
                        nxt_st.i2c_st = I2C_IDLE;
                    end
                end
                default: ;
            endcase
        end

        // Hardware set wins over a same-cycle clear
        nxt_st.mem[REG_IRQ_STATUS] = nxt_st.mem[REG_IRQ_STATUS] | irq_set;
        // pull low while enabled events pending
        nxt_st.int_oe_n = ~(|(nxt_st.mem[REG_IRQ_STATUS] &
                              nxt_st.mem[REG_IRQ_ENABLE]));
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_ff <= RST_STATE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sda_out = st_ff.pin_low;
    assign sda_oe_n_out = st_ff.sda_oe_n;
    assign int_out = st_ff.pin_low;
    assign int_oe_n_out = st_ff.int_oe_n;
    assign adc_sel_ir_out = st_ff.ch_ir;
    assign adc_integrate_out = st_ff.integ;
    assign power_state_out = st_ff.pwr;
    assign meas_busy_out = st_ff.busy;
endmodule
`default_nettype wire

// File: design/lus_pkg.sv
`default_nettype none
package lus_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_CTRL_SETUP_NS = 155000;
    localparam int T_ADC_SETUP_NS = 48800;
    localparam int T_CONV_UNIT_NS = 48800;
    localparam int T_INTEG_NS = 24400;
    localparam int T_RATE_TICK_NS = 1000000;
    localparam int CTRL_SETUP_CYC =
        (T_CTRL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADC_SETUP_CYC =
        (T_ADC_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_UNIT_CYC =
        (T_CONV_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INTEG_CYC = (T_INTEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RATE_TICK_CYC = T_RATE_TICK_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 27;

    localparam logic [6:0] SLV_ADDR_MAIN = 7'h55;
    localparam logic [6:0] SLV_ADDR_ALT = 7'h52;
    localparam int PTR_INHIBIT_BIT = 6;

    localparam logic [5:0] REG_PART_ID = 6'h00;
    localparam logic [5:0] REG_COMMAND = 6'h01;
    localparam logic [5:0] REG_CHAN_SEL = 6'h02;
    localparam logic [5:0] REG_VIS_GAIN = 6'h03;
    localparam logic [5:0] REG_IR_GAIN = 6'h04;
    localparam logic [5:0] REG_MEAS_RATE = 6'h05;
    localparam logic [5:0] REG_RES_MODE = 6'h06;
    localparam logic [5:0] REG_IRQ_STATUS = 6'h07;
    localparam logic [5:0] REG_IRQ_ENABLE = 6'h08;
    localparam logic [5:0] REG_THRESH_H = 6'h09;
    localparam logic [5:0] REG_THRESH_L = 6'h0A;
    localparam logic [5:0] REG_VIS_RES0 = 6'h10;
    localparam logic [5:0] REG_IR_RES0 = 6'h13;

    localparam logic [7:0] CMD_FORCE = 8'h11;
    localparam logic [7:0] CMD_PAUSE = 8'h12;
    localparam logic [7:0] CMD_START = 8'h13;

    localparam int CHAN_VIS_BIT = 0;
    localparam int CHAN_IR_BIT = 1;
    localparam int RES24_BIT = 0;
    localparam int IRQ_VIS_BIT = 0;
    localparam int IRQ_IR_BIT = 1;
    localparam int IRQ_THR_BIT = 2;

    localparam logic [7:0] CHAN_SEL_RST = 8'h03;
    localparam logic [23:0] SAT24 = 24'h7FFFFF;
    localparam logic [15:0] SAT16 = 16'hFFFF;

    typedef enum logic [3:0] {
        I2C_IDLE = 4'h0,
        I2C_ADDR = 4'h1,
        I2C_ADDR_ACK = 4'h2,
        I2C_PTR = 4'h3,
        I2C_PTR_ACK = 4'h4,
        I2C_WDATA = 4'h5,
        I2C_WDATA_ACK = 4'h6,
        I2C_RDATA = 4'h7,
        I2C_RACK = 4'h8
    } lus_i2c_st_t;

    typedef enum logic [2:0] {
        SEQ_SLEEP = 3'h0,
        SEQ_CTRL = 3'h1,
        SEQ_ADCSET = 3'h2,
        SEQ_CONV = 3'h3,
        SEQ_STORE = 3'h4
    } lus_seq_st_t;

    typedef enum logic [1:0] {
        PWR_SLEEP = 2'h0,
        PWR_ACTIVE = 2'h1,
        PWR_SUSPEND = 2'h2
    } lus_pwr_t;
endpackage
`default_nettype wire

// File: testbench/lus_readout_monitor.sv
`default_nettype none
module lus_readout_monitor (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n_out,
    input wire logic int_out,
    input wire logic int_oe_n_out,
    input wire logic adc_integrate_out,
    input wire lus_pkg::lus_pwr_t power_state_out,
    input wire logic meas_busy_out
);
    import lus_pkg::*;
    logic [15:0] integ_cnt;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);
    // Length of the running integration window
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            integ_cnt <= 16'h0000;
        end else begin
            integ_cnt <= adc_integrate_out ? integ_cnt + 16'h0001 : 16'h0000;
        end
    end
    sequence s_meas_start;
        $rose(meas_busy_out);
    endsequence
    sequence s_susp_entry;
        $rose(power_state_out == PWR_SUSPEND);
    endsequence
    sequence s_scl_held;
        scl_in[*6] ##0 !int_oe_n_out;
    endsequence
    a_sda_drive_low: assert property (!sda_oe_n_out |-> !sda_out)
        else $error("sda driven high");
    a_int_drive_low: assert property (!int_oe_n_out |-> !int_out)
        else $error("int driven high");
    a_int_held_low: assert property (s_scl_held |=> !int_oe_n_out)
        else $error("int released without host clear");
    a_sda_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
        else $error("sda changed while scl high");
    a_integ_in_susp: assert property (
        adc_integrate_out |-> power_state_out == PWR_SUSPEND)
        else $error("integration outside suspend");
    a_setup_active: assert property (
        s_meas_start |-> ##1 (power_state_out == PWR_ACTIVE)[*8])
        else $error("controller setup not active");
    a_adc_setup_gap: assert property (
        s_susp_entry |-> (!adc_integrate_out)[*8])
        else $error("integration without converter setup");
    a_integ_length: assert property ($fell(adc_integrate_out) |->
        integ_cnt inside {16'd976, 16'd1952, 16'd3904, 16'd7808})
        else $error("integration window length wrong");
    a_idle_sleep: assert property (
        $fell(meas_busy_out) |-> ##[0:2] power_state_out == PWR_SLEEP)
        else $error("no sleep after measurement");
endmodule
bind lus_readout lus_readout_monitor u_mon (.mclk_in, .arst_n_in, .scl_in,
    .sda_out, .sda_oe_n_out, .int_out, .int_oe_n_out, .adc_integrate_out,
    .power_state_out, .meas_busy_out);
`default_nettype wire

// File: testbench/lus_host_model.sv
`default_nettype none
module lus_host_model (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 4;
    initial begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #2;
    endtask
    task automatic put_bit(input logic b, output logic r);
        sda_oe_n_out = b;
        tick(HALF);
        scl_out = 1'b1;
        tick(2 * HALF);
        r = sda_in;
        scl_out = 1'b0;
        tick(HALF);
    endtask
    task automatic start();
        sda_oe_n_out = 1'b1;
        tick(HALF);
        scl_out = 1'b1;
        tick(2 * HALF);
        sda_oe_n_out = 1'b0;
        tick(2 * HALF);
        scl_out = 1'b0;
        tick(HALF);
    endtask
    task automatic stop();
        sda_oe_n_out = 1'b0;
        tick(HALF);
        scl_out = 1'b1;
        tick(2 * HALF);
        sda_oe_n_out = 1'b1;
        tick(2 * HALF);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(d[i], r);
        put_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(last, r);
    endtask
endmodule
`default_nettype wire

// File: testbench/light_uv_sensor_host_readout_tb.sv
`default_nettype none
module light_uv_sensor_host_readout_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lus_pkg::*;
    // Arbitrary identification value
    localparam logic [7:0] PART_ID_V = 8'hC3;
    logic mclk = 1'b0;
    logic arst_n, scl, sda_h_oe_n, sda_out, sda_oe_n_out;
    logic int_out, int_oe_n_out, vis_ovf, ir_ovf, sel_ir, integ, busy;
    logic [23:0] vis_sig, vis_dark, ir_sig, ir_dark;
    lus_pwr_t pwr;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    wire logic sda = (sda_oe_n_out ? 1'b1 : sda_out) & sda_h_oe_n;
    always #12.5 mclk = ~mclk;
    lus_host_model u_host (.mclk_in(mclk), .sda_in(sda), .scl_out(scl),
        .sda_oe_n_out(sda_h_oe_n));
    lus_readout #(.CTRL_SETUP_CYCLES(20), .RATE_TICK_CYCLES(50),
        .PART_ID(PART_ID_V)) u_dut (.mclk_in(mclk), .arst_n_in(arst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n_out(sda_oe_n_out), .int_out(int_out),
        .int_oe_n_out(int_oe_n_out), .vis_sig_in(vis_sig),
        .vis_dark_in(vis_dark), .vis_ovf_in(vis_ovf), .ir_sig_in(ir_sig),
        .ir_dark_in(ir_dark), .ir_ovf_in(ir_ovf), .adc_sel_ir_out(sel_ir),
        .adc_integrate_out(integ), .power_state_out(pwr),
        .meas_busy_out(busy));
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [23:0] exp_res(logic [23:0] s, logic [23:0] d,
                                            logic ovf, logic m24);
        logic [23:0] v;
        v = (s > d) ? s - d : 24'h000000;
        if (m24) return (ovf || v > SAT24) ? SAT24 : v;
        return (ovf || v > 24'h00FFFF) ? {SAT16, 8'h00} : {v[15:0], 8'h00};
    endfunction
    task automatic wr_regs(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d[$], output logic ack);
        logic a;
        u_host.start();
        u_host.send({dev, 1'b0}, ack);
        if (ack === 1'b1) begin
            u_host.send(ptr, a);
            foreach (d[i]) u_host.send(d[i], a);
        end
        u_host.stop();
    endtask
    task automatic rd_regs(input logic [7:0] ptr, input int n,
                           output logic [7:0] q[$]);
        logic a;
        logic [7:0] b;
        q = {};
        u_host.start();
        u_host.send({SLV_ADDR_MAIN, 1'b0}, a);
        u_host.send(ptr, a);
        u_host.start();
        u_host.send({SLV_ADDR_MAIN, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            u_host.recv(i == n - 1, b);
            q.push_back(b);
        end
        u_host.stop();
    endtask
    task automatic wait_idle();
        int w;
        w = 0;
        while (busy !== 1'b0 && w < 30000) begin
            u_host.tick(1);
            w++;
        end
        check("idle", 24'(busy), 24'h000000);
    endtask
    task automatic run_meas(input logic [7:0] chan, input logic m24,
                            input logic ovf, input logic neg);
        logic [7:0] q[$];
        logic a;
        vis_sig = 24'($urandom);
        vis_dark = neg ? vis_sig + 24'h000005
                       : vis_sig - 24'($urandom % 131072);
        ir_sig = 24'($urandom);
        ir_dark = ir_sig - 24'($urandom % 65536);
        vis_ovf = ovf;
        ir_ovf = 1'($urandom);
        wr_regs(SLV_ADDR_MAIN, {2'b00, REG_CHAN_SEL},
            '{chan, 8'h00, 8'h01, 8'h00, {7'h00, m24}, 8'hFF, 8'h03}, a);
        check("int clear", 24'(int_oe_n_out), 24'h000001);
        wr_regs(SLV_ADDR_MAIN, {2'b00, REG_COMMAND}, '{CMD_FORCE}, a);
        check("busy", 24'(busy), 24'h000001);
        check("sel ir", 24'(sel_ir), 24'(!chan[0]));
        wait_idle();
        u_host.tick(50);
        check("int held", 24'(int_oe_n_out), 24'h000000);
        rd_regs({2'b00, REG_IRQ_STATUS}, 1, q);
        check("status", 24'(q[0] & 8'h03), 24'(chan & 8'h03));
        rd_regs({2'b00, REG_VIS_RES0}, 6, q);
        check("vis res", {q[0], q[1], q[2]},
            exp_res(vis_sig, vis_dark, ovf, m24));
        if (chan[1]) check("ir res", {q[3], q[4], q[5]},
            exp_res(ir_sig, ir_dark, ir_ovf, m24));
        $display("test meas %h done", chan);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 95000) begin
            n_mismatch++;
            $display("timeout after %0d cycles", cyc);
            test_done();
        end
    end
    initial begin
        logic [7:0] q[$];
        logic a;
        logic [7:0] th_h;
        logic [7:0] th_l;
        arst_n = 1'b0;
        vis_sig = 24'h000000;
        vis_dark = 24'h000000;
        ir_sig = 24'h000000;
        ir_dark = 24'h000000;
        vis_ovf = 1'b0;
        ir_ovf = 1'b0;
        void'($urandom(43907));
        repeat (6) @(posedge mclk);
        #2 arst_n = 1'b1;
        u_host.tick(5);
        rd_regs(8'h00, 3, q);
        check("part id", 24'(q[0]), 24'(PART_ID_V));
        check("chan sel", 24'(q[2]), 24'(CHAN_SEL_RST));
        $display("test reset done");
        th_h = 8'($urandom);
        th_l = 8'($urandom);
        wr_regs(SLV_ADDR_ALT, {2'b00, REG_THRESH_H}, '{th_h, th_l}, a);
        check("alt ack", 24'(a), 24'h000001);
        wr_regs(7'h33, 8'h00, '{8'h00}, a);
        check("bad addr nack", 24'(a), 24'h000000);
        rd_regs({2'b00, REG_THRESH_H}, 2, q);
        check("burst rd", {8'h00, q[0], q[1]}, {8'h00, th_h, th_l});
        rd_regs({2'b01, REG_THRESH_H}, 2, q);
        check("fixed ptr", {8'h00, q[0], q[1]}, {8'h00, th_h, th_h});
        $display("test access done");
        run_meas(8'h03, 1'b0, 1'b0, 1'b0);
        run_meas(8'h01, 1'b1, 1'b1, 1'b0);
        run_meas(8'h01, 1'b1, 1'b0, 1'b1);
        run_meas(8'h03, 1'b0, 1'b1, 1'b0);
        wr_regs(SLV_ADDR_MAIN, {2'b00, REG_MEAS_RATE}, '{8'h01}, a);
        wr_regs(SLV_ADDR_MAIN, {2'b00, REG_COMMAND}, '{CMD_START}, a);
        u_host.tick(60);
        check("auto start", 24'(busy), 24'h000001);
        wait_idle();
        u_host.tick(60);
        check("auto repeat", 24'(busy), 24'h000001);
        wr_regs(SLV_ADDR_MAIN, {2'b00, REG_COMMAND}, '{CMD_PAUSE}, a);
        $display("test autonomous done");
        test_done();
    end
endmodule
`default_nettype wire
